//--- rtl/rdc_pkg.sv
// Constants and types for the rod drive command sequencer
//
// What this block does
// - Build two redundant operator messages, compare them, transmit only when identical
// - Message carries selected unit address plus action; only that unit answers
// - Rebuild, compare and send channel A message once every millisecond while a rod is selected
// - Motion needs an unbroken message train; stopped messages stop valves
// - Message or echo mismatch blocks motion; recovers when the cause clears
// - Operator mode lasts 0.0002 s, serving the selected rod and status
// - Scan mode lasts 0.045 s, polling non-selected rods one at a time
// - Self test, about 20 to 100 s, exercises one unit at a time
// - Any discrepancy or failure inhibits motion and raises activity disagree
// - Inhibit holds until the discrepancy or failure is corrected
// - Selection latched until another rod chosen or explicit deselect
// - During a movement cycle no reselection or deselection is accepted
// - Momentary insert gives timed insert then timed settle, one notch
// - Holding insert gives continuous insertion
// - Continuous insert holds insert; release drops it at once, no settle
// - Withdraw: insert, then withdraw and settle; withdraw drops before settle
// - A failed cycle timer prevents any further rod motion
// - Withdraw plus continuous withdraw: brief insert, continuous withdraw, settle
// - External rod blocks inhibit both movement and selection
// - Monitor inputs split in halves across two rod-block logic circuits
// - Minimizer withdraw block on one circuit; insert blocks stop insertion
package rdc_pkg;

  // Clock and mode durations
  localparam int unsigned     CLK_NS       = 100;
  localparam int unsigned     MS_NS        = 1_000_000;
  localparam logic [31:0]     MS_CYC_DEF   = 32'(MS_NS / CLK_NS);
  localparam int unsigned     OPER_NS      = 200_000;
  localparam logic [31:0]     OPER_CYC     = 32'(OPER_NS / CLK_NS);
  localparam int unsigned     SCAN_US      = 45_000;
  localparam logic [31:0]     SCAN_CYC_DEF = 32'(SCAN_US * 1000 / CLK_NS);
  localparam longint unsigned TEST_NS      = 64'd20_000_000_000;
  localparam logic [31:0]     TEST_CYC_DEF = 32'(TEST_NS / 64'(CLK_NS));

  // Valve phase lengths in milliseconds
  localparam logic [7:0] INS_MS    = 8'h04;
  localparam logic [7:0] SETTLE_MS = 8'h06;
  localparam logic [7:0] WD_INS_MS = 8'h01;
  localparam logic [7:0] WD_MS     = 8'h03;
  localparam logic [7:0] WDOG_MS   = 8'h14;

  localparam logic [7:0] ROD_N = 8'h64;
  localparam int         MON_N = 7;

  // Debounced input vector layout
  localparam int IN_INS   = 0;
  localparam int IN_WD    = 1;
  localparam int IN_CINS  = 2;
  localparam int IN_CWD   = 3;
  localparam int IN_MONA  = 4;
  localparam int IN_MONB  = IN_MONA + MON_N;
  localparam int IN_WMWD  = IN_MONB + MON_N;
  localparam int IN_WMINS = IN_WMWD + 1;
  localparam int IN_SQWD  = IN_WMWD + 2;
  localparam int IN_SQINS = IN_WMWD + 3;
  localparam int NIN      = IN_WMWD + 4;

  // Action field of a message
  localparam logic [2:0] ACT_NONE = 3'h0;
  localparam logic [2:0] ACT_INS  = 3'h1;
  localparam logic [2:0] ACT_WD   = 3'h2;
  localparam logic [2:0] ACT_SET  = 3'h4;
  localparam logic [2:0] ACT_TEST = ACT_SET;

  // Register map and fields
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SCAN   = 8'h08;
  localparam int CTL_CLR_BIT  = 0;
  localparam int CTL_INJ_BIT  = 1;
  localparam int CTL_HOLD_BIT = 2;
  localparam int ST_SEL_BIT   = 8;
  localparam int ST_ACT_LSB   = 9;
  localparam int ST_DIS_BIT   = 12;
  localparam int ST_TF_BIT    = 13;
  localparam int ST_WDB_BIT   = 14;
  localparam int ST_INB_BIT   = 15;
  localparam int ST_MODE_LSB  = 16;
  localparam int ST_TDUE_BIT  = 19;
  localparam int SC_STAT_LSB  = 8;

  typedef enum logic [8:0] {
    V_IDLE     = 9'h001,
    V_INS_RUN  = 9'h002,
    V_INS_SET  = 9'h004,
    V_CONT_INS = 9'h008,
    V_WD_INS   = 9'h010,
    V_WD_MOVE  = 9'h020,
    V_WD_SET   = 9'h040,
    V_CONT_WD  = 9'h080,
    V_WAIT_REL = 9'h100
  } rdc_vst_t;

  typedef enum logic [2:0] {
    M_OPER = 3'h1,
    M_SCAN = 3'h2,
    M_TEST = 3'h4
  } rdc_mode_t;

  typedef struct packed {
    logic [NIN-1:0] smp;
    logic [NIN-1:0] deb_smp;
    logic [NIN-1:0] deb;
    logic [31:0]    ms_cnt;
    logic           ms_tick;
    logic           sel_valid;
    logic [7:0]     sel_rod;
    rdc_vst_t       vst;
    logic [7:0]     vtim;
    logic [7:0]     wdog;
    rdc_mode_t      mode;
    logic [31:0]    tim;
    logic           wait_echo;
    logic           chk_ops;
    logic [7:0]     sent_addr;
    logic [2:0]     sent_act;
    logic [31:0]    scan_cnt;
    logic [7:0]     scan_addr;
    logic [7:0]     last_scan;
    logic [7:0]     scan_stat;
    logic [31:0]    test_cnt;
    logic           test_due;
    logic [7:0]     test_addr;
    logic           disagree;
    logic           timer_fail;
    logic           inject;
    logic           hold;
    logic           msg_strobe;
    logic [7:0]     msg_addr;
    logic [2:0]     msg_act;
    logic           alarm;
    logic           inhibit;
    logic [31:0]    prdata;
    logic           pslverr;
    logic           pready;
  } rdc_state_t;

  localparam rdc_state_t RST_STATE = '{vst: V_IDLE, mode: M_SCAN, default: '0};

endpackage

//--- rtl/rdc_sequencer.sv
// Rod drive command sequencer: valve sequencing, redundant messaging, APB registers
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
module rdc_sequencer #(
  parameter logic [31:0] MS_CYC   = rdc_pkg::MS_CYC_DEF,
  parameter logic [31:0] SCAN_CYC = rdc_pkg::SCAN_CYC_DEF,
  parameter logic [31:0] TEST_CYC = rdc_pkg::TEST_CYC_DEF
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [7:0]                paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      pb_insert_i,
  input  wire logic                      pb_withdraw_i,
  input  wire logic                      pb_cont_insert_i,
  input  wire logic                      pb_cont_withdraw_i,
  input  wire logic                      sel_req_i,
  input  wire logic [7:0]                sel_rod_i,
  input  wire logic                      deselect_i,
  input  wire logic [rdc_pkg::MON_N-1:0] mon_a_blk_i,
  input  wire logic [rdc_pkg::MON_N-1:0] mon_b_blk_i,
  input  wire logic                      wm_withdraw_blk_i,
  input  wire logic                      wm_insert_blk_i,
  input  wire logic                      seq_withdraw_blk_i,
  input  wire logic                      seq_insert_blk_i,
  input  wire logic                      echo_valid_i,
  input  wire logic [7:0]                echo_addr_i,
  input  wire logic [2:0]                echo_ops_i,
  input  wire logic [7:0]                echo_status_i,
  output logic                           msg_strobe_o,
  output logic      [7:0]                msg_addr_o,
  output logic      [2:0]                msg_act_o,
  output logic                           activity_disagree_o,
  output logic                           rod_inhibit_o,
  output logic                           sel_valid_o,
  output logic      [7:0]                sel_rod_o
);
  import rdc_pkg::*;

  rdc_state_t     r_reg;
  rdc_state_t     r_next;
  logic [NIN-1:0] raw;
  logic [2:0]     act_a;
  logic [2:0]     act_b;
  logic           blk_a;
  logic           blk_b;
  logic           wd_blk;
  logic           ins_blk;
  logic           any_blk;
  logic           moving;
  logic           inh;
  logic           b_ins;
  logic           b_wd;
  logic           b_cins;
  logic           b_cwd;

  function automatic logic [2:0] act_of(input rdc_vst_t s);
    case (s)
      V_INS_RUN, V_CONT_INS, V_WD_INS: act_of = ACT_INS;
      V_INS_SET, V_WD_SET:             act_of = ACT_SET;
      V_WD_MOVE, V_CONT_WD:            act_of = ACT_WD | ACT_SET;
      default:                         act_of = ACT_NONE;
    endcase
  endfunction

  function automatic logic [7:0] nxt_rod(input logic [7:0] a);
    nxt_rod = (a == ROD_N - 8'h01) ? 8'h00 : a + 8'h01;
  endfunction

  assign raw = {seq_insert_blk_i, seq_withdraw_blk_i, wm_insert_blk_i, wm_withdraw_blk_i,
                mon_b_blk_i, mon_a_blk_i, pb_cont_withdraw_i, pb_cont_insert_i,
                pb_withdraw_i, pb_insert_i};

  assign b_ins   = r_reg.deb[IN_INS];
  assign b_wd    = r_reg.deb[IN_WD];
  assign b_cins  = r_reg.deb[IN_CINS];
  assign b_cwd   = r_reg.deb[IN_CWD];
  // Two rod-block circuits; minimizer withdraw block feeds only circuit A
  assign blk_a   = (|r_reg.deb[IN_MONA +: MON_N]) | r_reg.deb[IN_WMWD];
  assign blk_b   = |r_reg.deb[IN_MONB +: MON_N];
  assign wd_blk  = blk_a | blk_b | r_reg.deb[IN_SQWD];
  assign ins_blk = r_reg.deb[IN_WMINS] | r_reg.deb[IN_SQINS];
  assign any_blk = wd_blk | ins_blk;
  assign moving  = (r_reg.vst != V_IDLE) && (r_reg.vst != V_WAIT_REL);
  assign inh     = r_reg.disagree | r_reg.timer_fail;
  // Channel B decodes on its own; inject bit lets software prove the compare
  assign act_a   = act_of(r_reg.vst);
  assign act_b   = act_of(r_reg.vst) ^ {2'h0, r_reg.inject};

  always_comb begin
    logic       set_dis;
    logic       ok_echo;
    logic       clr_tf;
    logic       timed;
    logic       snd;
    logic [7:0] snd_addr;
    logic [2:0] snd_act;
    logic       snd_chk;
    set_dis  = 1'h0;
    ok_echo  = 1'h0;
    clr_tf   = 1'h0;
    timed    = 1'h0;
    snd      = 1'h0;
    snd_addr = 8'h00;
    snd_act  = ACT_NONE;
    snd_chk  = 1'h0;
    r_next   = r_reg;
    r_next.ms_tick    = 1'h0;
    r_next.msg_strobe = 1'h0;

    // Millisecond enable
    if (r_reg.ms_cnt == MS_CYC - 32'h1) begin
      r_next.ms_cnt  = 32'h0;
      r_next.ms_tick = 1'h1;
    end else begin
      r_next.ms_cnt = r_reg.ms_cnt + 32'h1;
    end

    // Level must hold over two ms samples; costs up to 2 ms of latency
    r_next.smp = raw;
    if (r_reg.ms_tick) begin
      r_next.deb_smp = r_reg.smp;
      for (int i = 0; i < NIN; i++) begin
        if (r_reg.smp[i] == r_reg.deb_smp[i]) begin
          r_next.deb[i] = r_reg.smp[i];
        end
      end
    end

    // Rod selection
    if (!moving && !any_blk) begin
      if (sel_req_i) begin
        r_next.sel_valid = 1'h1;
        r_next.sel_rod   = sel_rod_i;
      end else if (deselect_i) begin
        r_next.sel_valid = 1'h0;
      end
    end

    // Valve sequence
    case (r_reg.vst)
      V_IDLE: begin
        if (r_reg.sel_valid && !inh) begin
          if (b_cins && !ins_blk) begin
            r_next.vst = V_CONT_INS;
          end else if (b_ins && !ins_blk) begin
            r_next.vst = V_INS_RUN;
          end else if (b_wd && !wd_blk) begin
            r_next.vst = V_WD_INS;
          end
        end
      end
      V_INS_RUN: begin
        if (ins_blk) begin
          r_next.vst = V_WAIT_REL;
        end else if (!b_ins && r_reg.vtim >= INS_MS) begin
          r_next.vst = V_INS_SET;
        end
      end
      V_INS_SET: begin
        if (r_reg.vtim >= SETTLE_MS) begin
          r_next.vst = V_IDLE;
        end
      end
      V_CONT_INS: begin
        if (ins_blk) begin
          r_next.vst = V_WAIT_REL;
        end else if (!b_cins) begin
          r_next.vst = V_IDLE;
        end
      end
      V_WD_INS: begin
        if (r_reg.vtim >= WD_INS_MS) begin
          r_next.vst = (b_wd && b_cwd && !wd_blk) ? V_CONT_WD : V_WD_MOVE;
        end
      end
      V_WD_MOVE: begin
        if (r_reg.vtim >= WD_MS) begin
          r_next.vst = V_WD_SET;
        end
      end
      V_CONT_WD: begin
        if (!(b_wd && b_cwd) || wd_blk) begin
          r_next.vst = V_WD_SET;
        end
      end
      V_WD_SET: begin
        if (r_reg.vtim >= SETTLE_MS) begin
          r_next.vst = V_WAIT_REL;
        end
      end
      V_WAIT_REL: begin
        if (!(b_ins || b_wd || b_cins || b_cwd)) begin
          r_next.vst = V_IDLE;
        end
      end
      default: r_next.vst = V_WAIT_REL;
    endcase
    // Abort to wait-release so a held button cannot restart on recovery
    if (inh && moving) begin
      r_next.vst = V_WAIT_REL;
    end

    // Phase timer, with an independent watchdog over timed phases
    timed = (r_reg.vst == V_INS_SET) || (r_reg.vst == V_WD_INS) ||
            (r_reg.vst == V_WD_MOVE) || (r_reg.vst == V_WD_SET) ||
            ((r_reg.vst == V_INS_RUN) && !b_ins);
    if (r_next.vst != r_reg.vst || !timed) begin
      r_next.vtim = (r_next.vst != r_reg.vst) ? 8'h00 : r_reg.vtim;
      r_next.wdog = 8'h00;
    end else if (r_reg.ms_tick) begin
      if (!r_reg.hold && r_reg.vtim != 8'hFF) begin
        r_next.vtim = r_reg.vtim + 8'h01;
      end
      if (r_reg.wdog != 8'hFF) begin
        r_next.wdog = r_reg.wdog + 8'h01;
      end
    end

    // Echo check against the last message sent
    if (r_reg.wait_echo) begin
      if (echo_valid_i) begin
        r_next.wait_echo = 1'h0;
        if (echo_addr_i == r_reg.sent_addr &&
            (!r_reg.chk_ops || echo_ops_i == r_reg.sent_act)) begin
          ok_echo = 1'h1;
        end else begin
          set_dis = 1'h1;
        end
        if (r_reg.mode == M_SCAN) begin
          r_next.last_scan = r_reg.sent_addr;
          r_next.scan_stat = echo_status_i;
        end
        if (r_reg.mode == M_TEST && ok_echo) begin
          r_next.test_due  = 1'h0;
          r_next.test_addr = nxt_rod(r_reg.test_addr);
        end
      end else if (r_reg.tim == OPER_CYC - 32'h1) begin
        r_next.wait_echo = 1'h0;
        set_dis          = 1'h1;
      end
    end

    // Mode sequence: operator window each ms, then scan or self test
    r_next.tim = r_reg.tim + 32'h1;
    if (r_reg.ms_tick) begin
      r_next.mode = M_OPER;
      r_next.tim  = 32'h0;
      if (r_reg.sel_valid) begin
        if ({r_reg.sel_rod, act_a} == {r_reg.sel_rod, act_b}) begin
          snd      = 1'h1;
          snd_addr = r_reg.sel_rod;
          snd_act  = act_a;
          snd_chk  = 1'h1;
        end else begin
          set_dis = 1'h1;
        end
      end
    end else if (r_reg.mode == M_OPER && r_reg.tim == OPER_CYC - 32'h1) begin
      r_next.tim = 32'h0;
      snd        = 1'h1;
      if (r_reg.test_due) begin
        r_next.mode = M_TEST;
        snd_addr    = r_reg.test_addr;
        snd_act     = ACT_TEST;
        snd_chk     = 1'h1;
      end else begin
        r_next.mode = M_SCAN;
        snd_addr    = r_reg.scan_addr;
      end
    end
    if (snd) begin
      r_next.msg_strobe = 1'h1;
      r_next.msg_addr   = snd_addr;
      r_next.msg_act    = snd_act;
      r_next.sent_addr  = snd_addr;
      r_next.sent_act   = snd_act;
      r_next.chk_ops    = snd_chk;
      r_next.wait_echo  = 1'h1;
    end

    // Scan pointer skips the selected rod; self test becomes due periodically
    if (r_reg.scan_cnt == SCAN_CYC - 32'h1) begin
      r_next.scan_cnt  = 32'h0;
      r_next.scan_addr = nxt_rod(r_reg.scan_addr);
      if (r_reg.sel_valid && r_next.scan_addr == r_reg.sel_rod) begin
        r_next.scan_addr = nxt_rod(r_next.scan_addr);
      end
    end else begin
      r_next.scan_cnt = r_reg.scan_cnt + 32'h1;
    end
    if (r_reg.test_cnt == TEST_CYC - 32'h1) begin
      r_next.test_cnt = 32'h0;
      r_next.test_due = 1'h1;
    end else begin
      r_next.test_cnt = r_reg.test_cnt + 32'h1;
    end

    // APB: data prepared in setup so access completes with no wait
    r_next.pready = 1'h1;
    if (psel_i && !penable_i) begin
      r_next.pslverr = 1'h0;
      r_next.prdata  = 32'h0000_0000;
      if (paddr_i == REG_CTRL) begin
        r_next.prdata[CTL_INJ_BIT]  = r_reg.inject;
        r_next.prdata[CTL_HOLD_BIT] = r_reg.hold;
      end else if (paddr_i == REG_STATUS) begin
        r_next.prdata[7:0]                 = r_reg.sel_rod;
        r_next.prdata[ST_SEL_BIT]          = r_reg.sel_valid;
        r_next.prdata[ST_ACT_LSB +: 3]     = act_a;
        r_next.prdata[ST_DIS_BIT]          = r_reg.disagree;
        r_next.prdata[ST_TF_BIT]           = r_reg.timer_fail;
        r_next.prdata[ST_WDB_BIT]          = wd_blk;
        r_next.prdata[ST_INB_BIT]          = ins_blk;
        r_next.prdata[ST_MODE_LSB +: 3]    = r_reg.mode;
        r_next.prdata[ST_TDUE_BIT]         = r_reg.test_due;
      end else if (paddr_i == REG_SCAN) begin
        r_next.prdata[7:0]              = r_reg.last_scan;
        r_next.prdata[SC_STAT_LSB +: 8] = r_reg.scan_stat;
      end else begin
        r_next.pslverr = 1'h1;
      end
    end
    if (psel_i && penable_i && r_reg.pready && pwrite_i && paddr_i == REG_CTRL) begin
      r_next.inject = pwdata_i[CTL_INJ_BIT];
      r_next.hold   = pwdata_i[CTL_HOLD_BIT];
      clr_tf        = pwdata_i[CTL_CLR_BIT];
    end

    // Faults: a good echo clears disagree, but a new fault wins
    // Clear only while channels agree, else a good scan echo masks a standing mismatch
    if (ok_echo && act_a == act_b) begin
      r_next.disagree = 1'h0;
    end
    if (set_dis) begin
      r_next.disagree = 1'h1;
    end
    if (clr_tf) begin
      r_next.timer_fail = 1'h0;
    end
    if (timed && r_reg.wdog > WDOG_MS) begin
      r_next.timer_fail = 1'h1;
    end
    r_next.alarm   = r_next.disagree | r_next.timer_fail;
    r_next.inhibit = r_next.disagree | r_next.timer_fail;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= RST_STATE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata_o            = r_reg.prdata;
  assign pready_o            = r_reg.pready;
  assign pslverr_o           = r_reg.pslverr;
  assign msg_strobe_o        = r_reg.msg_strobe;
  assign msg_addr_o          = r_reg.msg_addr;
  assign msg_act_o           = r_reg.msg_act;
  assign activity_disagree_o = r_reg.alarm;
  assign rod_inhibit_o       = r_reg.inhibit;
  assign sel_valid_o         = r_reg.sel_valid;
  assign sel_rod_o           = r_reg.sel_rod;

  default clocking dcb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sent_agree_a: assert property (msg_strobe_o && r_reg.mode == M_OPER |->
    $past(act_a == act_b) && msg_act_o == $past(act_a))
    else $error("operator message sent without channel agreement");
  oper_tick_a: assert property (msg_strobe_o && r_reg.mode == M_OPER |->
    $past(r_reg.ms_tick) && msg_addr_o == $past(r_reg.sel_rod))
    else $error("operator message not tied to ms tick");
  mismatch_block_a: assert property ($past(r_reg.ms_tick && r_reg.sel_valid && act_a != act_b)
    |-> !msg_strobe_o && r_reg.disagree)
    else $error("channel mismatch did not block message");
  alarm_follow_a: assert property ((r_reg.disagree || r_reg.timer_fail) |->
    activity_disagree_o ##0 rod_inhibit_o)
    else $error("fault without alarm and inhibit");
  inhibit_stop_a: assert property (rod_inhibit_o |=> !moving)
    else $error("rod moving under inhibit");
  sel_hold_a: assert property ($past(moving) |-> $stable(r_reg.sel_rod) && r_reg.sel_valid)
    else $error("selection changed during movement");
  notch_settle_a: assert property (r_reg.vst == V_INS_RUN ##1 r_reg.vst == V_INS_SET |->
    $past(r_reg.vtim) >= INS_MS && !$past(b_ins) && act_a == ACT_SET)
    else $error("notch settle began early or wrongly");
  cont_release_a: assert property (r_reg.vst == V_CONT_INS && !b_cins |=>
    act_a == ACT_NONE)
    else $error("settle or insert after continuous insert release");
  wd_order_a: assert property ($fell(act_a[1]) && !$past(inh) |-> act_a[2])
    else $error("settle dropped with withdraw");
  timer_fail_a: assert property (r_reg.timer_fail |=> !moving)
    else $error("motion after timer failure");
  ins_block_a: assert property (ins_blk && r_reg.vst inside {V_INS_RUN, V_CONT_INS} |=>
    r_reg.vst == V_WAIT_REL)
    else $error("insert block did not stop insertion");

endmodule
`default_nettype wire

//--- test/rdc_unit_bank.sv
// Drive unit bank model that echoes each addressed message
`timescale 1ns/1ns
`default_nettype none
module rdc_unit_bank (
  input  wire logic       clk_i,
  input  wire logic       stb_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [2:0] act_i,
  input  wire logic       slow_i,
  input  wire logic       bad_i,
  output logic            ev_o,
  output logic      [7:0] ea_o,
  output logic      [2:0] eo_o,
  output logic      [7:0] es_o
);
  import rdc_pkg::*;
  int         cnt;
  logic [7:0] a;
  logic [2:0] o;
  initial {ev_o, ea_o, eo_o, es_o, a, o, cnt} = '0;
  always @(posedge clk_i) begin
    ev_o <= 1'b0;
    // Lines are not held between echoes
    ea_o <= ~ea_o;
    eo_o <= ~eo_o;
    es_o <= es_o + 8'h01;
    if (stb_i && addr_i < ROD_N) begin
      a <= addr_i;
      o <= act_i;
      cnt <= slow_i ? 1500 : 3;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      ev_o <= 1'b1;
      ea_o <= bad_i ? ~a : a;
      eo_o <= o;
      es_o <= {5'h00, o};
    end
  end
endmodule
`default_nettype wire

//--- test/tb_rod_drive_command_sequencer.sv
// Self-checking bench for the rod drive command sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_rod_drive_command_sequencer;
  import rdc_pkg::*;
  localparam logic [31:0] MS = 32'd4200;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, sreq = 0, desel = 0, slow = 0, bad = 0;
  logic [7:0]       paddr = '0, srq = '0, ea, es, maddr, srod, rod;
  logic [31:0]      pwd = '0, prd, rd;
  logic [3:0]       pb = '0, blk = '0;
  logic [MON_N-1:0] ma = '0, mb = '0;
  logic [2:0]       eo, mact;
  logic             prdy, perr, err, ev, mstb, dis, inh, sval, rec = 0;
  logic [2:0]       acts[$];
  logic [2:0]       ex[4] = '{ACT_NONE, ACT_INS, ACT_SET, ACT_NONE};
  int num_errors = 0, tests_run = 0, cyc = 0, nset = 0, nins = 0;

  rdc_sequencer #(.MS_CYC(MS), .SCAN_CYC(32'd2000), .TEST_CYC(32'd1000000)) dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .pb_insert_i(pb[0]), .pb_withdraw_i(pb[1]), .pb_cont_insert_i(pb[2]),
    .pb_cont_withdraw_i(pb[3]), .sel_req_i(sreq), .sel_rod_i(srq), .deselect_i(desel),
    .mon_a_blk_i(ma), .mon_b_blk_i(mb), .wm_withdraw_blk_i(blk[0]), .wm_insert_blk_i(blk[1]),
    .seq_withdraw_blk_i(blk[2]), .seq_insert_blk_i(blk[3]), .echo_valid_i(ev),
    .echo_addr_i(ea), .echo_ops_i(eo), .echo_status_i(es), .msg_strobe_o(mstb),
    .msg_addr_o(maddr), .msg_act_o(mact), .activity_disagree_o(dis), .rod_inhibit_o(inh),
    .sel_valid_o(sval), .sel_rod_o(srod));
  rdc_unit_bank bank (.clk_i(clk), .stb_i(mstb), .addr_i(maddr), .act_i(mact), .slow_i(slow),
    .bad_i(bad), .ev_o(ev), .ea_o(ea), .eo_o(eo), .es_o(es));

  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      num_errors++;
      print_verdict();
    end
  end
  // Action history seen by the selected unit
  always @(posedge clk) if (rec && mstb && maddr === rod) begin
    if (acts.size() == 0 || acts[$] !== mact) acts.push_back(mact);
    if (mact === ACT_SET) nset++;
    if (mact === ACT_INS) nins++;
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    forever begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic sel(logic [7:0] r, logic d);
    @(posedge clk);
    sreq <= ~d;
    desel <= d;
    srq <= r;
    @(posedge clk);
    sreq <= 1'b0;
    desel <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_ms(int k);
    repeat (k * int'(MS)) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("TB: checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(39067));
    repeat (12) @(posedge clk);
    chk("reset outputs", 0, {dis, inh, mstb, sval});
    rst_n <= 1'b1;
    rod = 8'($urandom_range(99));
    sel(rod, 1'b0);
    chk("selection", {1'b1, rod}, {sval, srod});
    apb(1'b1, REG_STATUS, 32'($urandom));
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("status sel", {1'b1, rod}, rd[8:0]);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped err", 1, err);
    sel(rod, 1'b1);
    chk("deselected", 0, sval);
    sel(rod, 1'b0);
    // Slow echoes must still count as good ones
    slow <= 1'b1;
    rec <= 1'b1;
    pb[0] <= 1'b1;
    wait_ms(3);
    pb[0] <= 1'b0;
    sel(rod ^ 8'h01, 1'b0);
    chk("reselect in cycle", {1'b1, rod}, {sval, srod});
    sel(rod, 1'b1);
    chk("deselect in cycle", {1'b1, rod}, {sval, srod});
    // Release debounce plus insert and settle phases need up to 13 ms
    wait_ms(14);
    rec <= 1'b0;
    chk("action steps", 4, acts.size());
    for (int i = 0; i < 4 && i < acts.size(); i++) chk("action", ex[i], acts[i]);
    chk("settle ms", 1, nset >= SETTLE_MS - 1 && nset <= SETTLE_MS + 1);
    chk("insert ms", 1, nins >= INS_MS - 1);
    chk("no disagree", 0, {dis, inh});
    sel(rod ^ 8'h01, 1'b0);
    chk("reselect after", rod ^ 8'h01, srod);
    slow <= 1'b0;
    bad <= 1'b1;
    ma[$urandom_range(MON_N - 1)] <= 1'b1;
    wait_ms(3);
    chk("echo disagree", 3, {dis, inh});
    bad <= 1'b0;
    // Channel B fault keeps the inhibit although echoes are good again
    apb(1'b1, REG_CTRL, 32'h0000_0001 << CTL_INJ_BIT);
    sel(rod, 1'b0);
    chk("blocked select", rod ^ 8'h01, srod);
    wait_ms(1);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("mismatch holds", 32'h7, {rd[ST_DIS_BIT], dis, inh});
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    wait_ms(2);
    chk("recovered", 0, {dis, inh});
    print_verdict();
  end
endmodule
`default_nettype wire
